// ### rtl/pds_pkg.sv
// Package for the pixel digital shift datapath: widths, modes, carriers
package pds_pkg;
    localparam int SAMPLE_W = 10;
    localparam int PIXEL_W = 10;
    // Shift-select field encodings, then reset and saturation values
    localparam logic [1:0] SHIFT_NONE = 2'h0;
    localparam logic [1:0] SHIFT_ONCE = 2'h1;
    localparam logic [1:0] SHIFT_TWICE = 2'h2;
    localparam logic [1:0] SHIFT_RESET = 2'h0;
    localparam logic [9:0] PIXEL_RESET = 10'h000;
    localparam logic [9:0] PIXEL_SAT = 10'h3FF;
    // Input sample beat
    typedef struct packed {
        logic valid;
        logic [SAMPLE_W-1:0] data;
    } pds_sample_type;
    // Output pixel beat; in eight-bit mode only bits 7:0 carry the pixel
    typedef struct packed {
        logic valid;
        logic [PIXEL_W-1:0] data;
    } pds_pixel_type;
endpackage : pds_pkg

// ### rtl/pds_shift.sv
// Per-pixel digital shift datapath with saturation and shift-select register
`timescale 1ns/100ps
// Functional notes
// - Ten-bit, no shift: sample passes unchanged
// - Ten-bit, shift once: bits 8..0, zero appended
// - Ten-bit, shift twice: bits 7..0, two zeros
// - Eight-bit, no shift: output bits 9..2
// - Eight-bit, shift once: output bits 8..1
// - Eight-bit, shift twice: output bits 7..0
// - Shift once saturates when bit 9 set
// - Shift twice saturates when bit 9 or 8
// - Writable shift-select field applies to all pixels
module pds_shift (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Configuration
    input wire logic mode_8bit,
    input wire logic shift_wr,
    input wire logic [1:0] shift_wdata,
    output logic [1:0] shift_select_register,
    // Sample stream from the converters
    input wire pds_pkg::pds_sample_type sample_in,
    // Pixel stream toward the output
    output pds_pkg::pds_pixel_type pixel_out
);
    logic rst_meta_r;
    logic rst_sync_r;
    logic [1:0] shift_r;
    logic [1:0] shift_nxt;
    pds_pkg::pds_pixel_type pix_r;
    pds_pkg::pds_pixel_type pix_nxt;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Unknown codes fold to no shift so the datapath never sees them
    wire shift_code_ok = (shift_wdata == pds_pkg::SHIFT_ONCE) || (shift_wdata == pds_pkg::SHIFT_TWICE);
    assign shift_nxt = shift_wr ? (shift_code_ok ? shift_wdata : pds_pkg::SHIFT_NONE) : shift_r;

    // Shift-select register, one setting for every pixel
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            shift_r <= pds_pkg::SHIFT_RESET;
        end else begin
            shift_r <= shift_nxt;
        end
    end
    assign shift_select_register = shift_r;

    // Bit selection and saturation
    wire [9:0] s = sample_in.data;
    wire once = (shift_r == pds_pkg::SHIFT_ONCE);
    wire twice = (shift_r == pds_pkg::SHIFT_TWICE);
    wire sat = (once && s[9]) || (twice && (s[9] || s[8]));
    wire [9:0] ten_val = twice ? {s[7:0], 2'h0} : (once ? {s[8:0], 1'h0} : s);
    wire [7:0] eight_val = twice ? s[7:0] : (once ? s[8:1] : s[9:2]);
    wire [9:0] eight_sat = {2'h0, 8'hFF};
    wire [9:0] sel_val = mode_8bit ? (sat ? eight_sat : {2'h0, eight_val}) : (sat ? pds_pkg::PIXEL_SAT : ten_val);
    assign pix_nxt.valid = sample_in.valid;
    assign pix_nxt.data = sample_in.valid ? sel_val : pix_r.data;

    // Registered pixel output, one cycle latency
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            pix_r <= '{valid: 1'b0, data: pds_pkg::PIXEL_RESET};
        end else begin
            pix_r <= pix_nxt;
        end
    end
    assign pixel_out = pix_r;

    // Assertions
    // Cross-check reference: scale a widened sample by a plain shift
    // The two spare top bits keep what a shift pushes out, so overflow shows
    wire [1:0] chk_amount = twice ? 2'h2 : (once ? 2'h1 : 2'h0);
    wire [11:0] chk_scaled = {2'h0, s} << chk_amount;
    wire chk_over = (chk_scaled[11:10] != 2'h0);

    // Slice checks, one per mode and shift
    // Ten-bit, no shift is a straight copy
    a_ten_pass: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (sample_in.valid && !mode_8bit && shift_r == pds_pkg::SHIFT_NONE)
        |=> pixel_out.data == $past(sample_in.data))
        else $error("ten-bit pass wrong");

    // Ten-bit, shift once below the saturation point
    a_ten_once: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (sample_in.valid && !mode_8bit && once && !sample_in.data[9])
        |=> pixel_out.data == {$past(sample_in.data[8:0]), 1'h0})
        else $error("ten-bit once wrong");

    // Ten-bit, shift twice below the saturation point
    a_ten_twice: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (sample_in.valid && !mode_8bit && twice && sample_in.data[9:8] == 2'h0)
        |=> pixel_out.data == {$past(sample_in.data[7:0]), 2'h0})
        else $error("ten-bit twice wrong");

    // Eight-bit, no shift drops the two fine bits
    a_eight_none: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (sample_in.valid && mode_8bit && shift_r == pds_pkg::SHIFT_NONE)
        |=> pixel_out.data == {2'h0, $past(sample_in.data[9:2])})
        else $error("eight-bit none wrong");

    // Eight-bit, shift once below the saturation point
    a_eight_once: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (sample_in.valid && mode_8bit && once && !sample_in.data[9])
        |=> pixel_out.data == {2'h0, $past(sample_in.data[8:1])})
        else $error("eight-bit once wrong");

    // Eight-bit, shift twice below the saturation point
    a_eight_twice: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (sample_in.valid && mode_8bit && twice && sample_in.data[9:8] == 2'h0)
        |=> pixel_out.data == {2'h0, $past(sample_in.data[7:0])})
        else $error("eight-bit twice wrong");

    // Saturation to all ones
    // Mode is taken at the sample edge, as the datapath uses it
    a_once_sat: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (sample_in.valid && once && sample_in.data[9])
        |=> pixel_out.data[7:0] == 8'hFF && ($past(mode_8bit) || pixel_out.data[9:8] == 2'h3))
        else $error("once sat wrong");

    // Either top bit set clips the twice-shifted word
    a_twice_sat: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (sample_in.valid && twice && sample_in.data[9:8] != 2'h0)
        |=> pixel_out.data[7:0] == 8'hFF && ($past(mode_8bit) || pixel_out.data[9:8] == 2'h3))
        else $error("twice sat wrong");

    // Shift-select register
    // Unused code lands as no shift
    a_bad_code: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (shift_wr && shift_wdata == 2'h3)
        |=> shift_r == pds_pkg::SHIFT_NONE)
        else $error("bad code kept");

    // Setting holds between writes
    a_sel_hold: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (!shift_wr)
        |=> $stable(shift_r))
        else $error("shift select drifted");

    // Valid shift codes are stored as written
    a_shift_load: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (shift_wr && shift_code_ok)
        |=> shift_r == $past(shift_wdata))
        else $error("shift code not stored");

    // Writing zero turns shifting off again
    a_none_load: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (shift_wr && shift_wdata == pds_pkg::SHIFT_NONE)
        |=> shift_r == pds_pkg::SHIFT_NONE)
        else $error("shift not cleared");

    // Stream pairing, hold and reset
    // One pixel beat for every sample beat
    a_valid_follow: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (1'h1)
        |=> pixel_out.valid == $past(sample_in.valid))
        else $error("pixel valid not paired");

    // Idle cycles leave the last pixel standing
    a_data_hold: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (!sample_in.valid)
        |=> $stable(pixel_out.data))
        else $error("pixel data moved while idle");

    // Eight-bit pixels keep the top two bits clear
    a_eight_upper: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (sample_in.valid && mode_8bit)
        |=> pixel_out.data[9:8] == 2'h0)
        else $error("eight-bit upper bits set");

    // Held in reset: no beats and no shift
    a_reset_quiet: assert property (@(posedge clk)
        (!rst_sync_r)
        |-> !pixel_out.valid && shift_r == pds_pkg::SHIFT_RESET)
        else $error("reset values wrong");

    // Independent cross-checks against the widened reference
    // Ten-bit output is the sample times two to the shift
    a_ten_scaled: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (sample_in.valid && !mode_8bit && !chk_over)
        |=> pixel_out.data == $past(chk_scaled[9:0]))
        else $error("ten-bit scaling wrong");

    // Ten-bit overflow of the product clips to full scale
    a_ten_overflow: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (sample_in.valid && !mode_8bit && chk_over)
        |=> pixel_out.data == pds_pkg::PIXEL_SAT)
        else $error("ten-bit overflow not clipped");

    // Eight-bit output is the top byte of the product
    a_eight_scaled: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (sample_in.valid && mode_8bit && !chk_over)
        |=> pixel_out.data == {2'h0, $past(chk_scaled[9:2])})
        else $error("eight-bit scaling wrong");

    // Eight-bit overflow of the product clips to full scale
    a_eight_overflow: assert property (@(posedge clk) disable iff (!rst_sync_r)
        (sample_in.valid && mode_8bit && chk_over)
        |=> pixel_out.data == {2'h0, 8'hFF})
        else $error("eight-bit overflow not clipped");

    // Main scenarios reached
    c_once: cover property (@(posedge clk) disable iff (!rst_sync_r) sample_in.valid && once);
    c_twice_sat: cover property (@(posedge clk) disable iff (!rst_sync_r) sample_in.valid && twice && sat);
    c_eight: cover property (@(posedge clk) disable iff (!rst_sync_r) sample_in.valid && mode_8bit && twice);
    c_bad_code: cover property (@(posedge clk) disable iff (!rst_sync_r) shift_wr && shift_wdata == 2'h3);
    c_eight_once_sat: cover property (@(posedge clk) disable iff (!rst_sync_r)
        sample_in.valid && mode_8bit && once && sat);
endmodule : pds_shift

// ### bench/pds_grabber.sv
// Frame grabber model taking pixel beats off the camera output
`timescale 1ns/100ps
module pds_grabber (
    // Clock
    input wire logic clk,
    // Operator control: clear the peak reading
    input wire logic peak_clr,
    // Pixel stream and what was captured
    input wire pds_pkg::pds_pixel_type pixel_in,
    output int beats,
    output logic [9:0] last_pixel,
    output logic [9:0] peak
);
    int count_r = 0;
    logic [9:0] peak_r = 10'h000;
    assign beats = count_r;
    assign peak = peak_r;
    // No back-pressure on this link, so every valid beat is taken
    always @(posedge clk) begin
        if (pixel_in.valid === 1'b1) begin
            count_r <= count_r + 1;
            last_pixel <= pixel_in.data;
        end
    end
    // Brightest reading since the last clear, as the operator notes it
    always @(posedge clk) begin
        if (peak_clr) begin
            peak_r <= 10'h000;
        end else if (pixel_in.valid === 1'b1 && pixel_in.data > peak_r) begin
            peak_r <= pixel_in.data;
        end
    end
endmodule : pds_grabber

// ### bench/pds_shift_tb.sv
// Self-checking bench for the pixel digital shift datapath
`timescale 1ns/100ps
module pds_shift_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic mode_8bit = 1'b0;
    logic shift_wr = 1'b0;
    logic [1:0] shift_wdata = 2'h0;
    logic [1:0] shift_q;
    pds_pkg::pds_sample_type sample_in = '0;
    pds_pkg::pds_pixel_type pixel_out;
    int beats, sent = 0, mismatches = 0, n_checks = 0;
    logic [9:0] grabbed;
    logic peak_clr = 1'b0;
    logic [9:0] peak;
    always #50 clk = ~clk;
    pds_shift DUT (.clk(clk), .reset_n(reset_n), .mode_8bit(mode_8bit), .shift_wr(shift_wr),
        .shift_wdata(shift_wdata), .shift_select_register(shift_q), .sample_in(sample_in), .pixel_out(pixel_out));
    pds_grabber grabber (.clk(clk), .peak_clr(peak_clr), .pixel_in(pixel_out), .beats(beats), .last_pixel(grabbed),
        .peak(peak));
    // Inputs move 1 ns after the edge so the design never races the bench
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input logic [10:0] got, input logic [10:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Expected pixel; all-ones wins over the shifted bits
    function automatic logic [9:0] exp_pix(input logic m8, input logic [1:0] c, input logic [9:0] s);
        if ((c == pds_pkg::SHIFT_ONCE && s[9]) || (c == pds_pkg::SHIFT_TWICE && (s[9] | s[8]))) return m8 ? 10'h0FF : 10'h3FF;
        if (c == pds_pkg::SHIFT_ONCE) return m8 ? {2'h0, s[8:1]} : {s[8:0], 1'b0};
        if (c == pds_pkg::SHIFT_TWICE) return m8 ? {2'h0, s[7:0]} : {s[7:0], 2'h0};
        return m8 ? {2'h0, s[9:2]} : s;
    endfunction : exp_pix
    task automatic set_shift(input logic [1:0] code);
        sample_in.valid = 1'b0;
        tick;
        shift_wr = 1'b1;
        shift_wdata = code;
        tick;
        shift_wr = 1'b0;
    endtask : set_shift
    // Samples go back to back; each pixel is judged the cycle after
    task automatic send(input logic [9:0] s, input logic [9:0] exp);
        sample_in = '{valid: 1'b1, data: s};
        tick;
        sent++;
        check(pixel_out, {1'b1, exp});
    endtask : send
    task automatic t_sweep(input logic m8);
        logic [9:0] s[5] = '{10'h0FF, 10'h1AB, 10'h2C3, 10'h3FF, 10'h001};
        mode_8bit = m8;
        for (int c = 0; c < 3; c++) begin
            set_shift(c[1:0]);
            check({9'h0, shift_q}, {9'h0, c[1:0]});
            foreach (s[i]) send(s[i], exp_pix(m8, c[1:0], s[i]));
        end
        $display("Sweep done, eight-bit=%0d", m8);
    endtask : t_sweep
    task automatic t_register;
        check({9'h0, shift_q}, {9'h0, pds_pkg::SHIFT_RESET});
        set_shift(2'h3);
        check({9'h0, shift_q}, 11'h0);
        send(10'h3C7, 10'h3C7);
        $display("Register test done");
    endtask : t_register
    // Reset in mid-run must drop the stored shift back to none
    task automatic t_midreset;
        mode_8bit = 1'b0;
        set_shift(pds_pkg::SHIFT_TWICE);
        reset_n = 1'b0;
        repeat (2) tick;
        check(pixel_out, 11'h0);
        check({9'h0, shift_q}, {9'h0, pds_pkg::SHIFT_RESET});
        reset_n = 1'b1;
        repeat (3) tick;
        send(10'h0C5, 10'h0C5);
        $display("Mid-run reset test done");
    endtask : t_midreset
    // Operator procedure: read the unshifted peak, then take the largest safe shift
    task automatic t_operator(input logic m8, input logic [9:0] a, input logic [9:0] b, input logic [1:0] c_exp);
        logic [9:0] ra;
        logic [9:0] rb;
        logic [9:0] top;
        logic [1:0] code;
        ra = exp_pix(m8, pds_pkg::SHIFT_NONE, a);
        rb = exp_pix(m8, pds_pkg::SHIFT_NONE, b);
        top = (ra > rb) ? ra : rb;
        mode_8bit = m8;
        set_shift(pds_pkg::SHIFT_NONE);
        peak_clr = 1'b1;
        tick;
        peak_clr = 1'b0;
        send(a, ra);
        send(b, rb);
        sample_in.valid = 1'b0;
        tick;
        check({1'h0, peak}, {1'h0, top});
        code = pds_pkg::SHIFT_NONE;
        if (peak < (m8 ? 10'h080 : 10'h200)) code = pds_pkg::SHIFT_ONCE;
        if (peak < (m8 ? 10'h040 : 10'h100)) code = pds_pkg::SHIFT_TWICE;
        check({9'h0, code}, {9'h0, c_exp});
        set_shift(code);
        send(a, exp_pix(m8, code, a));
        send(b, exp_pix(m8, code, b));
        $display("Operator test done, eight-bit=%0d shift=%0d", m8, code);
    endtask : t_operator
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (6) tick;
        check(pixel_out, 11'h0);
        reset_n = 1'b1;
        repeat (3) tick;
        t_register;
        t_midreset;
        t_operator(1'b0, 10'h0C8, 10'h064, pds_pkg::SHIFT_TWICE);
        t_operator(1'b0, 10'h12C, 10'h0C8, pds_pkg::SHIFT_ONCE);
        t_operator(1'b0, 10'h258, 10'h064, pds_pkg::SHIFT_NONE);
        t_operator(1'b1, 10'h0A0, 10'h050, pds_pkg::SHIFT_TWICE);
        t_operator(1'b1, 10'h190, 10'h0A0, pds_pkg::SHIFT_ONCE);
        t_operator(1'b1, 10'h300, 10'h050, pds_pkg::SHIFT_NONE);
        t_sweep(1'b0);
        t_sweep(1'b1);
        sample_in.valid = 1'b0;
        tick;
        check(beats[10:0], sent[10:0]);
        check({1'b0, grabbed}, 11'h001);
        report_and_stop;
    end
endmodule : pds_shift_tb
